// ---- smsp_pkg.sv ----
// constants for the byte-wide serial port and its peer
// assumes a 100 MHz system clock and a 32-bit classic wishbone bus
package smsp_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SMSP_OFS_CTRL = 8'h00;
    localparam logic [7:0] SMSP_OFS_STATUS = 8'h04;
    localparam logic [7:0] SMSP_OFS_DATA = 8'h08;
    localparam logic [7:0] SMSP_OFS_DIR = 8'h0c;
    // ------------------------------------------------------------------
    // port_control_reg fields
    // ------------------------------------------------------------------
    localparam int SMSP_C_IRQ_EN = 7;
    localparam int SMSP_C_ENABLE = 6;
    localparam int SMSP_C_ORDER = 5;
    localparam int SMSP_C_MASTER = 4;
    localparam int SMSP_C_CLOCK_IDLE_LEVEL = 3;
    localparam int SMSP_C_CLOCK_SAMPLE_PHASE = 2;
    localparam int SMSP_C_RATE_HI = 1;
    localparam int SMSP_C_RATE_LO = 0;
    localparam logic [7:0] SMSP_CTRL_RST = 8'h00;
    // ------------------------------------------------------------------
    // port_status_reg fields
    // ------------------------------------------------------------------
    localparam int SMSP_S_DONE = 7;
    localparam int SMSP_S_WRITE_COLLISION_FLAG = 6;
    localparam int SMSP_S_DOUBLE = 0;
    // ------------------------------------------------------------------
    // pin direction register fields
    // ------------------------------------------------------------------
    localparam int SMSP_D_MOSI = 0;
    localparam int SMSP_D_MISO = 1;
    localparam int SMSP_D_SCK = 2;
    localparam int SMSP_D_SS = 3;
    localparam int SMSP_D_SS_LVL = 4;
    localparam logic [4:0] SMSP_DIR_RST = 5'h00;
    // ------------------------------------------------------------------
    // timing: sck half periods in clk cycles, index {double,hi,lo}
    // ------------------------------------------------------------------
    localparam logic [6:0] SMSP_HALF_4 = 7'h02;
    localparam logic [6:0] SMSP_HALF_16 = 7'h08;
    localparam logic [6:0] SMSP_HALF_64 = 7'h20;
    localparam logic [6:0] SMSP_HALF_128 = 7'h40;
    localparam logic [6:0] SMSP_HALF_2 = 7'h01;
    localparam logic [6:0] SMSP_HALF_8 = 7'h04;
    localparam logic [6:0] SMSP_HALF_32 = 7'h10;
    localparam logic [3:0] SMSP_LAST_EDGE = 4'hf;
endpackage

// ---- smsp_link_if.sv ----
// serial link between the port and its peer
// assumes the bench joins both modports; undriven lines read high
`timescale 1ns/1ps
interface smsp_link_if;
    logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
    logic dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_oe;
    logic peer_sck_o, peer_sck_oe, peer_mosi_o, peer_mosi_oe;
    logic peer_miso_o, peer_miso_oe, peer_ss_n_o, peer_ss_oe;
    logic sck, mosi, miso, ss_n;
    // ------------------------------------------------------------------
    // wire resolution with pull-up
    // ------------------------------------------------------------------
    assign sck = dev_sck_oe ? dev_sck_o : (peer_sck_oe ? peer_sck_o : 1'b1);
    assign mosi = dev_mosi_oe ? dev_mosi_o :
                  (peer_mosi_oe ? peer_mosi_o : 1'b1);
    assign miso = dev_miso_oe ? dev_miso_o :
                  (peer_miso_oe ? peer_miso_o : 1'b1);
    assign ss_n = dev_ss_oe ? dev_ss_n_o : (peer_ss_oe ? peer_ss_n_o : 1'b1);
    modport dev (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
                 dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_oe,
                 input sck, mosi, miso, ss_n);
    modport peer (output peer_sck_o, peer_sck_oe, peer_mosi_o, peer_mosi_oe,
                  peer_miso_o, peer_miso_oe, peer_ss_n_o, peer_ss_oe,
                  input sck, mosi, miso, ss_n);
endinterface

// ---- smsp_peer.sv ----
// far end of the link: a simple master or slave under user control
// assumes link inputs synchronous to clk_i
`timescale 1ns/1ps
module smsp_peer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    smsp_link_if.peer link,
    input wire logic master_i,
    input wire logic select_i,
    input wire logic clock_idle_level_i,
    input wire logic clock_sample_phase_i,
    input wire logic lsb_first_i,
    input wire logic [6:0] half_i,
    input wire logic start_i,
    input wire logic [7:0] tx_data_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rx_data_o
);
    import smsp_pkg::*;
    logic [7:0] sh, rx;
    logic [6:0] div;
    logic [3:0] e;
    logic run, sck_int, sck_prev;
    wire sel = ~master_i & ~link.ss_n;
    wire m_tick = run & master_i & (div == half_i - 7'd1);
    wire s_edge = sel & (link.sck != sck_prev);
    wire edge_ev = m_tick | s_edge;
    wire samp = edge_ev & (e[0] == clock_sample_phase_i);
    wire setup = edge_ev & (e[0] != clock_sample_phase_i) & ~(clock_sample_phase_i & (e == 4'h0));
    wire last = edge_ev & (e == SMSP_LAST_EDGE);
    wire din = master_i ? link.miso : link.mosi;
    wire [7:0] rx_next = lsb_first_i ? {din, rx[7:1]} : {rx[6:0], din};
    wire dout = lsb_first_i ? sh[0] : sh[7];
    wire busy = run | (sel & (e != 4'h0));
    // ------------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sh <= 8'h00;
            rx <= 8'h00;
            div <= 7'h00;
            e <= 4'h0;
            run <= 1'b0;
            sck_int <= 1'b0;
            sck_prev <= 1'b0;
            done_o <= 1'b0;
            rx_data_o <= 8'h00;
            busy_o <= 1'b0;
        end else begin
            sck_prev <= link.sck;
            done_o <= last;
            busy_o <= busy;
            if (start_i && !busy) begin
                sh <= tx_data_i;
                run <= master_i;
                div <= 7'h00;
                e <= 4'h0;
            end else if (run) begin
                div <= m_tick ? 7'h00 : div + 7'd1;
            end
            if (!run) begin
                sck_int <= clock_idle_level_i;
            end else if (m_tick) begin
                sck_int <= ~sck_int;
            end
            if (!master_i && link.ss_n) begin
                e <= 4'h0;
            end else if (edge_ev) begin
                e <= e + 4'd1;
            end
            if (samp) begin
                rx <= rx_next;
            end
            if (setup) begin
                sh <= lsb_first_i ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
            end
            if (last) begin
                run <= 1'b0;
                rx_data_o <= samp ? rx_next : rx;
            end
        end
    end
    // ------------------------------------------------------------------
    // link drivers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link.peer_sck_o <= 1'b0;
            link.peer_sck_oe <= 1'b0;
            link.peer_mosi_o <= 1'b0;
            link.peer_mosi_oe <= 1'b0;
            link.peer_miso_o <= 1'b0;
            link.peer_miso_oe <= 1'b0;
            link.peer_ss_n_o <= 1'b1;
            link.peer_ss_oe <= 1'b0;
        end else begin
            link.peer_sck_o <= sck_int;
            link.peer_sck_oe <= master_i;
            link.peer_mosi_o <= dout;
            link.peer_mosi_oe <= master_i;
            link.peer_miso_o <= dout;
            link.peer_miso_oe <= sel;
            link.peer_ss_n_o <= ~select_i;
            link.peer_ss_oe <= master_i;
        end
    end
endmodule

// ---- smsp_port.sv ----
// byte-wide serial port, master or slave, behind a wishbone slave
// assumes link inputs synchronous to clk_i; one request at a time
`timescale 1ns/1ps
// Operation
// - master software drives slave select low first
// - master data write shifts eight bits out
// - master stops after byte, sets done flag
// - mosi master to slave, miso back, together
// - master raises select after packet or continues
// - unselected slave idles, miso released
// - slave takes writes unselected, shifts when selected
// - slave sets done flag after full byte
// - slave may load before reading received byte
// - last received byte held in receive buffer
// - transmit single buffered, no load while busy
// - software reads byte before next completes
// - external master keeps sck at most clk/4
// - enabled port forces listed pins to input
// - lsb first or msb first selectable
// - double rate with rate bits 00 gives sck at clk/2
// - polarity sets idle level, phase sample edge
// - rate bits divide by 4..128 in master
// - busy write sets collision; status-then-data clears
// - select low in master drops to slave
module smsp_port (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    smsp_link_if.dev link
);
    import smsp_pkg::*;
    logic [7:0] port_control_reg, sh, rx, rxbuf;
    logic [4:0] dir;
    logic transfer_done_flag, write_collision_flag, double_rate;
    logic seen_done, seen_write_collision_flag;
    logic [6:0] div;
    logic [3:0] e;
    logic run, sck_int, sck_prev;
    logic [2:0] samp_q, last_q;
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire port_enable = port_control_reg[SMSP_C_ENABLE];
    wire master_select = port_control_reg[SMSP_C_MASTER];
    wire bit_order = port_control_reg[SMSP_C_ORDER];
    wire clock_idle_level = port_control_reg[SMSP_C_CLOCK_IDLE_LEVEL];
    wire clock_sample_phase = port_control_reg[SMSP_C_CLOCK_SAMPLE_PHASE];
    wire en_m = port_enable & master_select;
    wire en_s = port_enable & ~master_select;
    wire acc = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire wr_lane = wb_we_i & wb_sel_i[0];
    wire a_ctrl = wb_adr_i == SMSP_OFS_CTRL;
    wire a_stat = wb_adr_i == SMSP_OFS_STATUS;
    wire a_data = wb_adr_i == SMSP_OFS_DATA;
    wire a_dir = wb_adr_i == SMSP_OFS_DIR;
    wire data_acc = acc & a_data;
    wire data_wr = data_acc & wr_lane;
    wire stat_rd = acc & a_stat & ~wb_we_i;
    wire [2:0] rate = {double_rate, port_control_reg[SMSP_C_RATE_HI],
                       port_control_reg[SMSP_C_RATE_LO]};
    logic [6:0] half;
    always_comb begin
        case (rate)
            3'h0: half = SMSP_HALF_4;
            3'h1: half = SMSP_HALF_16;
            3'h2: half = SMSP_HALF_64;
            3'h3: half = SMSP_HALF_128;
            3'h4: half = SMSP_HALF_2;
            3'h5: half = SMSP_HALF_8;
            3'h6: half = SMSP_HALF_32;
            default: half = SMSP_HALF_64;
        endcase
    end
    // ------------------------------------------------------------------
    // edge events
    // ------------------------------------------------------------------
    wire slave_sel = en_s & ~link.ss_n;
    wire mode_fault = en_m & ~dir[SMSP_D_SS] & ~link.ss_n;
    wire m_tick = run & (div == half - 7'd1);
    wire s_edge = slave_sel & (link.sck != sck_prev);
    wire edge_ev = m_tick | s_edge;
    wire samp = edge_ev & (e[0] == clock_sample_phase);
    wire setup = edge_ev & (e[0] != clock_sample_phase) &
                 ~(clock_sample_phase & (e == 4'h0));
    wire last = edge_ev & (e == SMSP_LAST_EDGE);
    // master takes miso three clocks late: one for its own pin, two for a
    // slave that samples sck with this clock; slave takes it at once
    wire cap = master_select ? samp_q[2] : samp;
    wire cap_last = master_select ? last_q[2] : last;
    wire din = master_select ? link.miso : link.mosi;
    wire [7:0] rx_next = bit_order ? {din, rx[7:1]} : {rx[6:0], din};
    wire dout = bit_order ? sh[0] : sh[7];
    wire busy = run | (|last_q) | (slave_sel & (e != 4'h0));
    wire start = data_wr & ~busy & en_m;
    wire [31:0] rd_word = a_ctrl ? {24'h0, port_control_reg} :
        a_stat ? {24'h0, transfer_done_flag, write_collision_flag, 5'h00,
                  double_rate} :
        a_data ? {24'h0, rxbuf} :
        a_dir ? {27'h0, dir} : 32'h0;
    // ------------------------------------------------------------------
    // bus slave and registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            port_control_reg <= SMSP_CTRL_RST;
            dir <= SMSP_DIR_RST;
            double_rate <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= rd_word;
            if (acc && wr_lane && a_ctrl) begin
                port_control_reg <= wb_dat_i[7:0];
            end else if (mode_fault) begin
                port_control_reg[SMSP_C_MASTER] <= 1'b0;
            end
            if (acc && wr_lane && a_stat) begin
                double_rate <= wb_dat_i[SMSP_S_DOUBLE];
            end
            if (acc && wr_lane && a_dir) begin
                dir <= wb_dat_i[4:0];
            end
        end
    end
    // ------------------------------------------------------------------
    // status flags, set wins over clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            transfer_done_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            seen_done <= 1'b0;
            seen_write_collision_flag <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            if (cap_last || mode_fault) begin
                transfer_done_flag <= 1'b1;
            end else if (data_acc && seen_done) begin
                transfer_done_flag <= 1'b0;
            end
            if (data_wr && busy) begin
                write_collision_flag <= 1'b1;
            end else if (data_acc && seen_write_collision_flag) begin
                write_collision_flag <= 1'b0;
            end
            if (stat_rd) begin
                seen_done <= transfer_done_flag;
                seen_write_collision_flag <= write_collision_flag;
            end else if (data_acc) begin
                seen_done <= 1'b0;
                seen_write_collision_flag <= 1'b0;
            end
            irq_o <= transfer_done_flag & port_control_reg[SMSP_C_IRQ_EN];
        end
    end
    // ------------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sh <= 8'h00;
            rx <= 8'h00;
            rxbuf <= 8'h00;
            div <= 7'h00;
            e <= 4'h0;
            run <= 1'b0;
            sck_int <= 1'b0;
            sck_prev <= 1'b0;
            samp_q <= 3'h0;
            last_q <= 3'h0;
        end else begin
            sck_prev <= link.sck;
            samp_q <= {samp_q[1:0], samp & master_select};
            last_q <= {last_q[1:0], last & master_select};
            if (data_wr && !busy) begin
                sh <= wb_dat_i[7:0];
            end else if (setup) begin
                sh <= bit_order ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
            end
            if (start) begin
                run <= 1'b1;
                div <= 7'h00;
            end else if (last || mode_fault || !en_m) begin
                run <= 1'b0;
            end else if (run) begin
                div <= m_tick ? 7'h00 : div + 7'd1;
            end
            if (!run) begin
                sck_int <= clock_idle_level;
            end else if (m_tick) begin
                sck_int <= ~sck_int;
            end
            if (start || mode_fault || (!en_m && !slave_sel)) begin
                e <= 4'h0;
            end else if (edge_ev) begin
                e <= e + 4'd1;
            end
            if (cap) begin
                rx <= rx_next;
            end
            if (cap_last) begin
                rxbuf <= cap ? rx_next : rx;
            end
        end
    end
    // ------------------------------------------------------------------
    // pin drivers and direction overrides
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link.dev_sck_o <= 1'b0;
            link.dev_sck_oe <= 1'b0;
            link.dev_mosi_o <= 1'b0;
            link.dev_mosi_oe <= 1'b0;
            link.dev_miso_o <= 1'b0;
            link.dev_miso_oe <= 1'b0;
            link.dev_ss_n_o <= 1'b0;
            link.dev_ss_oe <= 1'b0;
        end else begin
            link.dev_sck_o <= sck_int;
            link.dev_mosi_o <= dout;
            link.dev_miso_o <= dout;
            link.dev_ss_n_o <= dir[SMSP_D_SS_LVL];
            link.dev_sck_oe <= ~en_s & dir[SMSP_D_SCK];
            link.dev_mosi_oe <= ~en_s & dir[SMSP_D_MOSI];
            link.dev_ss_oe <= ~en_s & dir[SMSP_D_SS];
            link.dev_miso_oe <= ~en_m & dir[SMSP_D_MISO] &
                                ~(en_s & link.ss_n);
        end
    end
endmodule

// ---- smsp_link_sva.sv ----
// concurrent checks on the serial link between the port and its peer
// assumes the bench hands in the link lines and enables, one clock domain
`timescale 1ns/1ps
module smsp_link_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dev_sck_oe,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic dev_ss_oe,
    input wire logic peer_sck_oe,
    input wire logic peer_mosi_oe,
    input wire logic peer_miso_oe,
    input wire logic peer_ss_oe,
    input wire logic sck,
    input wire logic ss_n
);
    // ------------------------------------------------------------------
    // clock edges seen while the link stays selected
    // ------------------------------------------------------------------
    logic sck_q, ss_q;
    logic [4:0] edge_cnt;
    wire sel_edge = !ss_n && !ss_q && (sck != sck_q);
    always_ff @(posedge clk_i) begin
        sck_q <= sck;
        ss_q <= ss_n;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || ss_n) begin
            edge_cnt <= 5'h00;
        end else if (sel_edge) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_byte_whole: assert property (
        $rose(ss_n) |-> edge_cnt[3:0] == 4'h0)
        else $error("link deselected inside a byte");
    chk_miso_quiet: assert property (
        ss_n && $past(ss_n) && $past(ss_n, 2) |-> !dev_miso_oe)
        else $error("miso driven while slave unselected");
    chk_miso_late: assert property (
        $rose(dev_miso_oe) |-> !$past(ss_n))
        else $error("miso driven before select");
    chk_sck_single: assert property (
        !(dev_sck_oe && peer_sck_oe))
        else $error("sck driven from both ends");
    chk_mosi_single: assert property (
        !(dev_mosi_oe && peer_mosi_oe))
        else $error("mosi driven from both ends");
    chk_miso_single: assert property (
        !(dev_miso_oe && peer_miso_oe))
        else $error("miso driven from both ends");
    chk_ss_single: assert property (
        !(dev_ss_oe && peer_ss_oe))
        else $error("select driven from both ends");
    chk_fault_quiet: assert property (
        (!ss_n && !dev_ss_oe) [*4] |-> !dev_sck_oe && !dev_mosi_oe)
        else $error("port drives sck or mosi while selected");
endmodule

// ---- smsp_port_bench.sv ----
// self-checking bench: port and peer joined over the link interface
// assumes the package constants and the peer's documented handshake
`timescale 1ns/1ps
module smsp_port_bench;
    import smsp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, s;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic pm = 1'b0, psel = 1'b0, pcpol = 1'b0, pcpha = 1'b0, plsb = 1'b0;
    logic pstart = 1'b0, pbusy, pdone;
    logic [6:0] phalf = 7'h04;
    logic [7:0] ptx = 8'h00, prx;
    logic [2:0] k;
    logic [6:0] halves [8] = '{SMSP_HALF_4, SMSP_HALF_16, SMSP_HALF_64,
        SMSP_HALF_128, SMSP_HALF_2, SMSP_HALF_8, SMSP_HALF_32, SMSP_HALF_64};
    int error_cnt = 0, num_checks = 0, cyc_cnt = 0;
    smsp_link_if link();
    smsp_port smsp_port_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .link(link));
    smsp_peer smsp_peer_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
        .master_i(pm), .select_i(psel), .clock_idle_level_i(pcpol), .clock_sample_phase_i(pcpha),
        .lsb_first_i(plsb), .half_i(phalf), .start_i(pstart),
        .tx_data_i(ptx), .busy_o(pbusy), .done_o(pdone), .rx_data_o(prx));
    smsp_link_sva smsp_link_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
        .dev_miso_oe(link.dev_miso_oe), .dev_ss_oe(link.dev_ss_oe),
        .peer_sck_oe(link.peer_sck_oe), .peer_mosi_oe(link.peer_mosi_oe),
        .peer_miso_oe(link.peer_miso_oe), .peer_ss_oe(link.peer_ss_oe),
        .sck(link.sck), .ss_n(link.ss_n));
    always #5 clk_i = ~clk_i;
    // ------------------------------------------------------------------
    // compare, bus and peer helpers
    // ------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task bit_chk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        bit_chk(ack, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task poll;
        int n;
        n = 0;
        do begin
            wb(1'b0, SMSP_OFS_STATUS, 8'h00);
            n++;
        end while (rd[SMSP_S_DONE] !== 1'b1 && n < 800);
        bit_chk(rd[SMSP_S_DONE], 1'b1);
    endtask
    task next_edge(output int n);
        n = 0;
        s = link.sck;
        while (link.sck === s && n < 300) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task pgo(input logic [7:0] d);
        ptx <= d;
        pstart <= 1'b1;
        @(posedge clk_i);
        pstart <= 1'b0;
    endtask
    task pwait;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pdone !== 1'b1 && n < 1000);
        bit_chk(pdone, 1'b1);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task rtest;
        rdc(SMSP_OFS_CTRL, SMSP_CTRL_RST);
        rdc(SMSP_OFS_STATUS, 8'h00);
        rdc(SMSP_OFS_DIR, {3'h0, SMSP_DIR_RST});
        bit_chk(irq, 1'b0);
        wb(1'b1, 8'h10, 8'hff);
        rdc(8'h10, 8'h00);
        rdc(SMSP_OFS_CTRL, 8'h00);
        $display("reset test done");
    endtask
    task mxfer(input int i);
        logic [7:0] c, tx;
        int n;
        k = i[2:0];
        c = {k == 3'h0, 1'b1, k[0], 1'b1, k[1], k[2], k[1:0]};
        tx = 8'ha5 ^ {k, k, 2'b10};
        pm <= 1'b0;
        pcpol <= c[SMSP_C_CLOCK_IDLE_LEVEL];
        pcpha <= c[SMSP_C_CLOCK_SAMPLE_PHASE];
        plsb <= c[SMSP_C_ORDER];
        pgo(~tx ^ 8'h5a);
        wb(1'b1, SMSP_OFS_CTRL, c);
        wb(1'b1, SMSP_OFS_STATUS, {7'h0, k[2]});
        wb(1'b1, SMSP_OFS_DIR, 8'h1d);
        wb(1'b1, SMSP_OFS_DIR, 8'h0d);
        wb(1'b1, SMSP_OFS_DATA, tx);
        next_edge(n);
        next_edge(n);
        chk(32'(n), {25'h0, halves[k]});
        if (k == 3'h0) wb(1'b1, SMSP_OFS_DATA, 8'h00);
        poll;
        chk(rd, {24'h0, 1'b1, k == 3'h0, 5'h0, k[2]});
        bit_chk(irq, k == 3'h0);
        bit_chk(link.sck, c[SMSP_C_CLOCK_IDLE_LEVEL]);
        rdc(SMSP_OFS_DATA, ~tx ^ 8'h5a);
        chk({24'h0, prx}, {24'h0, tx});
        rdc(SMSP_OFS_STATUS, {7'h0, k[2]});
        bit_chk(irq, 1'b0);
        wb(1'b1, SMSP_OFS_DIR, 8'h1d);
        $display("master test %0d done", i);
    endtask
    task stest;
        wb(1'b1, SMSP_OFS_CTRL, 8'hec);
        wb(1'b1, SMSP_OFS_DIR, 8'h02);
        wb(1'b1, SMSP_OFS_DATA, 8'h96);
        pm <= 1'b1;
        repeat (4) @(posedge clk_i);
        bit_chk(link.dev_miso_oe, 1'b0);
        psel <= 1'b1;
        repeat (4) @(posedge clk_i);
        pgo(8'h5b);
        pwait;
        poll;
        bit_chk(irq, 1'b1);
        chk({24'h0, prx}, 32'h96);
        wb(1'b1, SMSP_OFS_DATA, 8'h18);
        pgo(8'he7);
        pwait;
        poll;
        rdc(SMSP_OFS_DATA, 8'he7);
        chk({24'h0, prx}, 32'h18);
        psel <= 1'b0;
        $display("slave test done");
    endtask
    task ftest;
        wb(1'b1, SMSP_OFS_CTRL, 8'h50);
        wb(1'b1, SMSP_OFS_DIR, 8'h00);
        psel <= 1'b1;
        poll;
        rdc(SMSP_OFS_CTRL, 8'h40);
        psel <= 1'b0;
        $display("mode fault test done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            error_cnt++;
            finish_test;
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rtest;
        for (int i = 0; i < 8; i++) begin
            mxfer(i);
        end
        stest;
        ftest;
        finish_test;
    end
endmodule
